// *** core/host_bus_params.svh ***
// Purpose: named constants of the host bus pin control block
// Assumes: 40 MHz core clock
// Notes:   included by bare name
`ifndef HOST_BUS_PARAMS_SVH
`define HOST_BUS_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS          25
`define ROM_T11_NS      4000
`define ROM_T10_NS      3200
`define ROM_T01_NS      1600
`define ROM_T00_NS      800
`define HALF_CYC(ns)    8'(((ns) / 2) / `CLK_NS)
`define READY_LAST      4'h7
`define STRAP_SETTLE    2'h3

// ----------------------------------------
// register map and reset values
// ----------------------------------------
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_ROM         4'h8
`define REG_SAMPLE      4'hC
`define CTRL_RESET      15'h3030
`define RELOAD_BIT      15
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ----------------------------------------
// configuration memory serial access
// ----------------------------------------
`define ROM_READ_CMD    9'h180
`define ROM_CMD_LAST    5'h08
`define ROM_DATA_LAST   5'h0F
`define ROM_WIDTH_BIT   0
`define WIDE_VARIANT    1'b0

`endif

// *** core/host_bus_pkg.sv ***
// Purpose: types of the host bus pin control block
// Assumes: nothing
// Notes:   layouts of control and state
package host_bus_pkg;

	typedef enum logic [1:0] {MODE_SYNC, MODE_ASYNC8, MODE_ASYNC16, MODE_BURST} mode_t;

	typedef enum logic [1:0] {ROM_IDLE, ROM_SEND, ROM_RECV, ROM_END} rom_state_t;

	typedef struct packed {
		logic        latch_en;
		logic [1:0]  speed;
		logic [11:0] base;
	} ctrl_t;

	typedef struct packed {
		rom_state_t  state;
		logic [7:0]  div;
		logic [4:0]  cnt;
		logic [8:0]  sh;
		logic        clk;
		logic        sel;
		logic [15:0] data;
		logic        done;
	} rom_regs_t;

	typedef struct packed {
		logic        aw_full;
		logic [3:0]  awaddr;
		logic        w_full;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		ctrl_t       ctrl;
		logic [14:0] latch_addr;
		logic        latch_qual;
		logic        ads_q;
		logic        bclk_q;
		logic [14:0] samp_addr;
		logic        samp_dir;
		logic        samp_cyc;
		logic        samp_qual;
		logic [1:0]  settle;
		logic        strap_done;
		mode_t       mode;
		logic        rom_en;
		logic [15:0] rom_word;
		logic        rom_start;
		logic        ready_hold;
		logic [3:0]  ready_cnt;
		logic        strobe_q;
	} top_regs_t;

endpackage

// *** core/cfg_rom_if.sv ***
// Purpose: control link between pin control and the serial memory engine
// Assumes: one clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/10ps
interface cfg_rom_if;
	logic        start;
	logic        halt;
	logic [7:0]  half;
	logic        busy;
	logic        done;
	logic [15:0] data;
	modport ctl (output start, halt, half, input busy, done, data);
	modport eng (input start, halt, half, output busy, done, data);
endinterface

// *** core/bit_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are levels
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta  <= '0;
			q_out <= '0;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule

// *** core/cfg_rom_engine.sv ***
// Purpose: reads one configuration word from a serial memory
// Assumes: rx_in already synchronised
// Notes:   halt aborts at once and idles the pins
`timescale 1ns/10ps
`include "host_bus_params.svh"
module cfg_rom_engine (
	input  wire logic clk_in,
	input  wire logic rst_in,
	cfg_rom_if.eng    ctl,
	input  wire logic rx_in,
	output logic      select_out,
	output logic      clock_out,
	output logic      tx_out
);
	host_bus_pkg::rom_regs_t r;
	host_bus_pkg::rom_regs_t next_r;
	logic                    tick;

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		tick = (r.div == ctl.half - 8'h01);
		case (r.state)
			host_bus_pkg::ROM_IDLE: begin
				if (ctl.start) begin
					next_r.state = host_bus_pkg::ROM_SEND;
					next_r.sel   = 1'b1;
					next_r.sh    = `ROM_READ_CMD;
					next_r.div   = 8'h00;
					next_r.cnt   = 5'h00;
					next_r.clk   = 1'b0;
					next_r.data  = 16'h0000;
				end
			end
			host_bus_pkg::ROM_SEND, host_bus_pkg::ROM_RECV: begin
				next_r.div = tick ? 8'h00 : r.div + 8'h01;
				if (tick && !r.clk) begin
					next_r.clk = 1'b1;
					if (r.state == host_bus_pkg::ROM_RECV) begin
						next_r.data = {r.data[14:0], rx_in};
					end
				end else if (tick) begin
					next_r.clk = 1'b0;
					next_r.cnt = r.cnt + 5'h01;
					if (r.state == host_bus_pkg::ROM_SEND) begin
						next_r.sh = {r.sh[7:0], 1'b0};
						if (r.cnt == `ROM_CMD_LAST) begin
							next_r.state = host_bus_pkg::ROM_RECV;
							next_r.cnt   = 5'h00;
						end
					end else if (r.cnt == `ROM_DATA_LAST) begin
						next_r.state = host_bus_pkg::ROM_END;
					end
				end
			end
			host_bus_pkg::ROM_END: begin
				next_r.sel   = 1'b0;
				next_r.done  = 1'b1;
				next_r.state = host_bus_pkg::ROM_IDLE;
			end
			default: begin
				next_r.state = host_bus_pkg::ROM_IDLE;
			end
		endcase
		if (ctl.halt) begin
			next_r.state = host_bus_pkg::ROM_IDLE;
			next_r.sel   = 1'b0;
			next_r.clk   = 1'b0;
			next_r.sh    = 9'h000;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign ctl.busy   = (r.state != host_bus_pkg::ROM_IDLE);
	assign ctl.done   = r.done;
	assign ctl.data   = r.data;
	assign select_out = r.sel;
	assign clock_out  = r.clk;
	assign tx_out     = r.sh[8];
endmodule

// *** core/host_bus_pin_control.sv ***
// Purpose: pin-level control of a non-PCI host bus port
// Assumes: 40 MHz clk_in; all pins asynchronous to it
// Notes:   registers on AXI4-Lite; bus clock sampled as a pin
`timescale 1ns/10ps
`include "host_bus_params.svh"
module host_bus_pin_control (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [3:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [3:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	input  wire logic [15:1] addr_in,
	input  wire logic        addr_qualify_n_in,
	input  wire logic        read_strobe_n_in,
	input  wire logic        write_strobe_n_in,
	input  wire logic        command_cycle_n_in,
	input  wire logic        sync_direction_in,
	input  wire logic        addr_latch_strobe_n_in,
	input  wire logic        chip_sleep_n_in,
	input  wire logic        bus_clk_in,
	input  wire logic        bus_mode_strap_in,
	input  wire logic        cfg_rom_enable_strap_in,
	input  wire logic        cfg_rom_rx_in,
	output logic             local_select_n_out,
	output logic             async_ready_out,
	output logic             async_ready_oe_out,
	output logic             cfg_rom_select_out,
	output logic             cfg_rom_clock_out,
	output logic             cfg_rom_tx_out
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic decode_hit(input logic [11:0] a, input logic qual_n,
		input logic [11:0] base);
		return !qual_n && (a == base);
	endfunction

	function automatic logic [7:0] half_cycles(input logic [1:0] speed);
		case (speed)
			2'h0:    return `HALF_CYC(`ROM_T00_NS);
			2'h1:    return `HALF_CYC(`ROM_T01_NS);
			2'h2:    return `HALF_CYC(`ROM_T10_NS);
			default: return `HALF_CYC(`ROM_T11_NS);
		endcase
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [25:0] pins_q;
	logic [14:0] s_addr;
	logic        s_qual;
	logic        s_rd_n;
	logic        s_wr_n;
	logic        s_cyc_n;
	logic        s_dir;
	logic        s_ads_n;
	logic        s_sleep_n;
	logic        s_bclk;
	logic        s_mode_strap;
	logic        s_rom_strap;
	logic        s_rx;

	bit_sync #(.WIDTH(26)) pin_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   ({addr_in, addr_qualify_n_in, read_strobe_n_in, write_strobe_n_in,
			command_cycle_n_in, sync_direction_in, addr_latch_strobe_n_in,
			chip_sleep_n_in, bus_clk_in, bus_mode_strap_in, cfg_rom_enable_strap_in,
			cfg_rom_rx_in}),
		.q_out  (pins_q)
	);

	assign {s_addr, s_qual, s_rd_n, s_wr_n, s_cyc_n, s_dir, s_ads_n, s_sleep_n, s_bclk,
		s_mode_strap, s_rom_strap, s_rx} = pins_q;

	// ----------------------------------------
	// serial configuration memory
	// ----------------------------------------
	host_bus_pkg::top_regs_t r;
	host_bus_pkg::top_regs_t next_r;
	cfg_rom_if               rom ();

	cfg_rom_engine rom_engine (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.ctl        (rom.eng),
		.rx_in      (s_rx),
		.select_out (cfg_rom_select_out),
		.clock_out  (cfg_rom_clock_out),
		.tx_out     (cfg_rom_tx_out)
	);

	assign rom.start = r.rom_start;
	assign rom.halt  = !s_sleep_n;
	assign rom.half  = half_cycles(r.ctrl.speed);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// with latch_en clear, decode stays combinational from the pins so select tracks the address with no clock delay
	logic raw_hit;
	logic latched_hit;
	logic sync_hit;
	logic access;

	assign raw_hit     = decode_hit(addr_in[15:4], addr_qualify_n_in, r.ctrl.base);
	assign latched_hit = decode_hit(r.latch_addr[14:3], r.latch_qual, r.ctrl.base);
	assign local_select_n_out = !(r.ctrl.latch_en ? latched_hit : raw_hit);
	assign sync_hit = r.ctrl.latch_en ? latched_hit :
		decode_hit(s_addr[14:3], s_qual, r.ctrl.base);
	assign access = (r.mode != host_bus_pkg::MODE_SYNC) && r.strap_done && s_sleep_n &&
		sync_hit && (!s_rd_n || !s_wr_n);

	// ----------------------------------------
	// state update
	// ----------------------------------------
	always_comb begin
		logic [14:0] c;
		c = r.ctrl;
		next_r = r;
		next_r.rom_start = 1'b0;

		// register bus: address and data taken in either order
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			next_r.aw_full = 1'b1;
			next_r.awaddr  = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			next_r.w_full = 1'b1;
			next_r.wdata  = s_axi_wdata_in;
			next_r.wstrb  = s_axi_wstrb_in;
		end
		if (r.aw_full && r.w_full) begin
			next_r.aw_full = 1'b0;
			next_r.w_full  = 1'b0;
			next_r.bvalid  = 1'b1;
			next_r.bresp   = `RESP_OKAY;
			case (r.awaddr)
				`REG_CTRL: begin
					if (r.wstrb[0]) begin
						c[7:0] = r.wdata[7:0];
					end
					if (r.wstrb[1]) begin
						c[14:8] = r.wdata[14:8];
						next_r.rom_start = r.wdata[`RELOAD_BIT] && r.rom_en && r.strap_done
							&& !rom.busy;
					end
					next_r.ctrl = c;
				end
				`REG_STATUS, `REG_ROM, `REG_SAMPLE: begin
				end
				default: begin
					next_r.bresp = `RESP_SLVERR;
				end
			endcase
		end
		if (r.bvalid && s_axi_bready_in) begin
			next_r.bvalid = 1'b0;
		end
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			next_r.rvalid = 1'b1;
			next_r.rresp  = `RESP_OKAY;
			case (s_axi_araddr_in)
				`REG_CTRL:   next_r.rdata = {17'h00000, r.ctrl};
				`REG_STATUS: next_r.rdata = {26'h0000000, rom.busy, !s_sleep_n, r.strap_done,
					r.rom_en, r.mode};
				`REG_ROM:    next_r.rdata = {16'h0000, r.rom_word};
				`REG_SAMPLE: next_r.rdata = {14'h0000, r.samp_cyc, r.samp_dir, r.samp_qual,
					r.samp_addr};
				default: begin
					next_r.rdata = 32'h00000000;
					next_r.rresp = `RESP_SLVERR;
				end
			endcase
		end else if (r.rvalid && s_axi_rready_in) begin
			next_r.rvalid = 1'b0;
		end

		// straps caught once the synchronisers have settled after reset
		if (!r.strap_done) begin
			next_r.settle = r.settle + 2'h1;
			if (r.settle == `STRAP_SETTLE) begin
				next_r.strap_done = 1'b1;
				next_r.rom_en     = s_rom_strap;
				next_r.rom_start  = s_rom_strap && s_sleep_n;
				if (!s_mode_strap) begin
					next_r.mode = host_bus_pkg::MODE_SYNC;
				end else if (`WIDE_VARIANT) begin
					next_r.mode = host_bus_pkg::MODE_BURST;
				end else if (!s_rom_strap && s_rx) begin
					next_r.mode = host_bus_pkg::MODE_ASYNC16;
				end else begin
					next_r.mode = host_bus_pkg::MODE_ASYNC8;
				end
			end
		end

		// width comes from the loaded word when the memory is fitted
		if (rom.done) begin
			next_r.rom_word = rom.data;
			if ((r.mode == host_bus_pkg::MODE_ASYNC8) || (r.mode == host_bus_pkg::MODE_ASYNC16))
				begin
				next_r.mode = rom.data[`ROM_WIDTH_BIT] ? host_bus_pkg::MODE_ASYNC16 :
					host_bus_pkg::MODE_ASYNC8;
			end
		end

		// address latching on the strobe rising edge
		// the synchroniser resets low, so wait for the straps or the idle-high strobe fakes a rise
		next_r.ads_q = s_ads_n;
		if (r.strap_done && s_ads_n && !r.ads_q) begin
			next_r.latch_addr = s_addr;
			next_r.latch_qual = s_qual;
		end

		// synchronous mode sampling on the bus clock rising edge
		next_r.bclk_q = s_bclk;
		if ((r.mode == host_bus_pkg::MODE_SYNC) && r.strap_done && s_bclk && !r.bclk_q) begin
			next_r.samp_addr = s_addr;
			next_r.samp_qual = s_qual;
			next_r.samp_cyc  = s_cyc_n;
			next_r.samp_dir  = s_dir;
		end else if ((r.mode == host_bus_pkg::MODE_BURST) && !s_cyc_n && r.strap_done) begin
			next_r.samp_dir = s_cyc_n ^ 1'b1;
		end

		// ready stretch: a fixed hold per access; a re-strobe inside it is not restarted
		next_r.strobe_q = access;
		if (access && !r.strobe_q && !r.ready_hold) begin
			next_r.ready_hold = 1'b1;
			next_r.ready_cnt  = 4'h0;
		end else if (r.ready_hold) begin
			next_r.ready_cnt = r.ready_cnt + 4'h1;
			if (r.ready_cnt == `READY_LAST) begin
				next_r.ready_hold = 1'b0;
			end
		end
		if (!s_sleep_n) begin
			next_r.ready_hold = 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			r      <= '0;
			r.ctrl <= `CTRL_RESET;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready_out  = !r.aw_full && !r.bvalid;
	assign s_axi_wready_out   = !r.w_full && !r.bvalid;
	assign s_axi_bvalid_out   = r.bvalid;
	assign s_axi_bresp_out    = r.bresp;
	assign s_axi_arready_out  = !r.rvalid;
	assign s_axi_rvalid_out   = r.rvalid;
	assign s_axi_rdata_out    = r.rdata;
	assign s_axi_rresp_out    = r.rresp;
	assign async_ready_out    = 1'b0;
	assign async_ready_oe_out = r.ready_hold;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [7:0] rom_age;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rom_age <= 8'h00;
		end else if ((cfg_rom_clock_out != $past(cfg_rom_clock_out)) ||
			(cfg_rom_select_out && !$past(cfg_rom_select_out))) begin
			rom_age <= 8'h01;
		end else begin
			rom_age <= rom_age + 8'h01;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence access_start;
		access && !r.strobe_q && !r.ready_hold && s_sleep_n;
	endsequence

	sequence ready_stretch;
		async_ready_oe_out [*8] ##1 !async_ready_oe_out;
	endsequence

	select_decode_a: assert property (!r.ctrl.latch_en && !addr_qualify_n_in &&
		(addr_in[15:4] == r.ctrl.base) |-> !local_select_n_out)
		else $error("select not asserted on base match");
	qualifier_gate_a: assert property (!r.ctrl.latch_en && addr_qualify_n_in
		|-> local_select_n_out)
		else $error("select asserted without qualifier");
	ready_stretch_a: assert property (disable iff (rst_in || !s_sleep_n)
		access_start |=> ready_stretch)
		else $error("ready stretch length wrong");
	mode_strap_a: assert property ($rose(r.strap_done) && !$past(s_mode_strap)
		|-> r.mode == host_bus_pkg::MODE_SYNC)
		else $error("sync mode not chosen from low strap");
	rom_gate_a: assert property (!r.rom_en |-> !cfg_rom_select_out)
		else $error("memory used while disabled");
	rom_clock_half_a: assert property (cfg_rom_select_out && $past(cfg_rom_select_out) &&
		$changed(cfg_rom_clock_out) |-> rom_age == half_cycles(r.ctrl.speed))
		else $error("memory clock half period wrong");
	width_strap_a: assert property ($rose(r.strap_done) && !r.rom_en &&
		$past(s_mode_strap) |-> r.mode == ($past(s_rx) ? host_bus_pkg::MODE_ASYNC16 :
		host_bus_pkg::MODE_ASYNC8))
		else $error("width strap not honoured");
	rom_width_a: assert property (rom.done && (r.mode != host_bus_pkg::MODE_SYNC)
		|=> r.mode == (rom.data[`ROM_WIDTH_BIT] ? host_bus_pkg::MODE_ASYNC16 :
		host_bus_pkg::MODE_ASYNC8))
		else $error("loaded width not applied");
	latch_capture_a: assert property (r.strap_done && s_ads_n && !r.ads_q |=>
		r.latch_addr == $past(s_addr) && r.latch_qual == $past(s_qual))
		else $error("address latch missed");
	sleep_ready_a: assert property (!s_sleep_n |=> !async_ready_oe_out)
		else $error("ready driven while asleep");
	sync_sample_a: assert property (r.mode == host_bus_pkg::MODE_SYNC && r.strap_done &&
		s_bclk && !r.bclk_q |=> r.samp_dir == $past(s_dir) && r.samp_addr == $past(s_addr))
		else $error("bus clock sample missed");
endmodule

// *** verification/host_model.sv ***
// Purpose: host bus master model driving the pin side
// Assumes: ready pin pulled up outside, level fed in
// Notes:   tasks are called from the bench
`timescale 1ns/10ps
module host_model (
	input  wire logic   clk_in,
	input  wire logic   ready_in,
	output logic [15:1] addr_out,
	output logic        qual_n_out,
	output logic        rd_n_out,
	output logic        wr_n_out,
	output logic        cyc_n_out,
	output logic        dir_out,
	output logic        bclk_out
);
	initial begin
		addr_out = 15'h0000;
		qual_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		cyc_n_out = 1'b1;
		dir_out = 1'b0;
		bclk_out = 1'b0;
	end
	task set_pins(input logic [15:1] a, input logic q, input logic d, input logic c);
		@(posedge clk_in);
		addr_out <= a;
		qual_n_out <= q;
		dir_out <= d;
		cyc_n_out <= c;
	endtask
	// holds the strobe until ready is given back, as a real host must
	task access(input logic wr, output int hold);
		int n;
		hold = 0;
		n = 0;
		@(posedge clk_in);
		if (wr) wr_n_out <= 1'b0;
		else rd_n_out <= 1'b0;
		while (ready_in && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		while (!ready_in && hold < 40) begin
			@(negedge clk_in);
			hold++;
		end
		@(posedge clk_in);
		rd_n_out <= 1'b1;
		wr_n_out <= 1'b1;
	endtask
	// bus clock runs only while the host is clocking an access
	task bclk_pulses(input int k);
		repeat (k) begin
			repeat (4) @(posedge clk_in);
			bclk_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			bclk_out <= 1'b0;
		end
	endtask
endmodule

// *** verification/testbench.sv ***
// Purpose: self-checking bench of the host bus pin control
// Assumes: 40 MHz clock, registers over AXI4-Lite
// Notes:   three resets cover the strap settings
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [15:1] addr;
	logic        qual_n, rd_n, wr_n, cyc_n, dir, bclk, sel_n, rdy, rdy_oe;
	logic        sleep_n = 1'b1, mode_strap = 1'b1, rom_strap = 1'b1, rx = 1'b1;
	logic        rom_sel, rom_clk, rom_tx;
	logic        ads_n = 1'b1, rom_out = 1'b1, rom_clk_q = 1'b0;
	logic [8:0]  cmd_seen = 9'h000;
	logic [15:0] rom_img = 16'hB2C7;
	int          rises = 0;
	wire         rx_pin = rom_sel ? rom_out : rx;
	wire         rdy_pin = rdy_oe ? rdy : 1'b1;
	int          err_total = 0, checked = 0, h;
	always #12.5 clk_in = ~clk_in;
	// stand-in serial memory: takes the command on clock rise, shifts its word out on clock fall
	always @(negedge clk_in) begin
		rom_clk_q <= rom_clk;
		if (!rom_sel) begin
			rises <= 0;
		end else if (rom_clk && !rom_clk_q) begin
			rises <= rises + 1;
			if (rises < 9) cmd_seen <= {cmd_seen[7:0], rom_tx};
		end else if (!rom_clk && rom_clk_q && rises >= 9 && rises < 25) begin
			rom_out <= rom_img[24 - rises];
		end
	end
	host_bus_pin_control host_bus_pin_control_inst (.clk_in(clk_in), .rst_in(rst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .addr_in(addr),
		.addr_qualify_n_in(qual_n), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
		.command_cycle_n_in(cyc_n), .sync_direction_in(dir), .addr_latch_strobe_n_in(ads_n),
		.chip_sleep_n_in(sleep_n), .bus_clk_in(bclk), .bus_mode_strap_in(mode_strap),
		.cfg_rom_enable_strap_in(rom_strap), .cfg_rom_rx_in(rx_pin), .local_select_n_out(sel_n),
		.async_ready_out(rdy), .async_ready_oe_out(rdy_oe), .cfg_rom_select_out(rom_sel),
		.cfg_rom_clock_out(rom_clk), .cfg_rom_tx_out(rom_tx));
	host_model host_model_inst (.clk_in(clk_in), .ready_in(rdy_pin), .addr_out(addr),
		.qual_n_out(qual_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .cyc_n_out(cyc_n),
		.dir_out(dir), .bclk_out(bclk));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task test_done;
		$display("counts: mismatches %0d, comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task tmo(input int n, input int lim);
		if (n >= lim) begin
			err_total++;
			$display("BAD wait exp %0d got %0d", lim, n);
			test_done;
		end
	endtask
	task do_reset(input logic m, input logic e, input logic x);
		@(posedge clk_in);
		rst_in <= 1'b1;
		mode_strap <= m;
		rom_strap <= e;
		rx <= x;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (10) @(posedge clk_in);
	endtask
	task axw(input logic [3:0] a, input logic [31:0] v);
		logic pa, pw, pb, ta, tw, tb;
		int   n;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		{pa, pw, pb} = 3'h7;
		n = 0;
		while (pb && n < 50) begin
			@(negedge clk_in);
			ta = pa && awready;
			tw = pw && wready;
			tb = bvalid;
			if (tb) r = bresp;
			@(posedge clk_in);
			if (ta) {awvalid, pa} <= 2'h0;
			if (tw) {wvalid, pw} <= 2'h0;
			if (tb) {bready, pb} <= 2'h0;
			n++;
		end
		tmo(n, 50);
	endtask
	task axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic pa, pr, ta, tr;
		int   n;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		{pa, pr} = 2'h3;
		n = 0;
		while (pr && n < 50) begin
			@(negedge clk_in);
			ta = pa && arready;
			tr = rvalid;
			if (tr) {v, rs} = {rdata, rresp};
			@(posedge clk_in);
			if (ta) {arvalid, pa} <= 2'h0;
			if (tr) {rready, pr} <= 2'h0;
			n++;
		end
		tmo(n, 50);
	endtask
	task rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
		axr(a, d, r);
		`CHK(nm, e, d)
	endtask
	task rom_half(output int hh);
		int n;
		n = 0;
		while (!rom_clk && n < 300) begin
			@(negedge clk_in);
			n++;
		end
		tmo(n, 300);
		`CHK("rom_tx", 1'b1, rom_tx)
		hh = 0;
		while (rom_clk && hh < 300) begin
			@(negedge clk_in);
			hh++;
		end
	endtask
	task rom_wait;
		int n;
		n = 0;
		while (rom_sel && n < 9000) begin
			@(negedge clk_in);
			n++;
		end
		tmo(n, 9000);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		do_reset(1'b1, 1'b1, 1'b1);
		rom_half(h);
		`CHK("half_11", 80, h)
		rom_wait;
		`CHK("rom_cmd", 9'h180, cmd_seen)
		rchk("rom", 4'h8, 32'h0000_B2C7);
		rchk("status", 4'h4, 32'h0000_000E);
		rchk("ctrl", 4'h0, 32'h0000_3030);
		axr(4'h2, d, r);
		`CHK("resp", 2'h2, r)
		axw(4'h2, 32'h0000_0000);
		`CHK("wresp", 2'h2, r)
		host_model_inst.set_pins(15'h0187, 1'b0, 1'b0, 1'b1);
		@(negedge clk_in);
		`CHK("sel_hit", 1'b0, sel_n)
		host_model_inst.set_pins(15'h0188, 1'b0, 1'b0, 1'b1);
		@(negedge clk_in);
		`CHK("sel_miss", 1'b1, sel_n)
		host_model_inst.set_pins(15'h0180, 1'b1, 1'b0, 1'b1);
		@(negedge clk_in);
		`CHK("sel_qual", 1'b1, sel_n)
		host_model_inst.set_pins(15'h0180, 1'b0, 1'b0, 1'b1);
		host_model_inst.access(1'b0, h);
		`CHK("hold_rd", 8, h)
		host_model_inst.access(1'b1, h);
		`CHK("hold_wr", 8, h)
		rom_img = 16'h4D38;
		axw(4'h0, 32'h0000_8030);
		`CHK("wresp_ok", 2'h0, r)
		rom_half(h);
		`CHK("half_00", 16, h)
		rchk("ctrl2", 4'h0, 32'h0000_0030);
		rom_wait;
		rchk("rom2", 4'h8, 32'h0000_4D38);
		@(posedge clk_in);
		sleep_n <= 1'b0;
		repeat (4) @(posedge clk_in);
		host_model_inst.access(1'b0, h);
		`CHK("hold_sleep", 0, h)
		rchk("status_sleep", 4'h4, 32'h0000_001D);
		sleep_n <= 1'b1;
		$display("test memory and async done");
		do_reset(1'b1, 1'b0, 1'b0);
		rchk("status_8", 4'h4, 32'h0000_0009);
		axw(4'h0, 32'h0000_7030);
		host_model_inst.set_pins(15'h0187, 1'b0, 1'b0, 1'b1);
		@(posedge clk_in);
		ads_n <= 1'b0;
		repeat (4) @(posedge clk_in);
		ads_n <= 1'b1;
		repeat (4) @(posedge clk_in);
		host_model_inst.set_pins(15'h0188, 1'b1, 1'b0, 1'b1);
		repeat (4) @(negedge clk_in);
		`CHK("sel_latch", 1'b0, sel_n)
		$display("test width strap and latch done");
		do_reset(1'b0, 1'b0, 1'b0);
		rchk("status_sync", 4'h4, 32'h0000_0008);
		host_model_inst.set_pins(15'h1234, 1'b0, 1'b1, 1'b0);
		host_model_inst.bclk_pulses(2);
		rchk("sample", 4'hC, 32'h0001_1234);
		host_model_inst.access(1'b0, h);
		`CHK("hold_sync", 0, h)
		$display("test sync mode done");
		test_done;
	end
endmodule
